// file: spsc_top.sv
// serial port with slave select handling, control register and bus slave
`timescale 1ns/100ps
// How it works
// [R01] slave mode: select pin always input
// [R02] selected slave: active, miso per direction
// [R03] deselected slave: all inputs, data ignored
// [R04] select rising resets shift logic and counter
// [R05] master: select pin is plain output
// [R06] master with select input: keep it high
// [R07] select low in master: drop to slave
// [R08] that drop sets flag, may interrupt
// [R09] handler checks master bit, software resets it
// [R10] control byte: ie,en,order,master_select_bit,cpol,cpha,rate
// [R11] order bit one sends lsb first
// [R12] polarity sets idle, phase picks sample edge
// [R13] master rate from rate bits and double
// [R14] select synchronised before any use
module spsc_top #(
	parameter int AW = 8
) (
	// clock, reset, enable
	input  wire logic          clock,
	input  wire logic          rst,
	input  wire logic          ce,
	// axi4-lite write
	input  wire logic [AW-1:0] awaddr,
	input  wire logic          awvalid,
	output logic               awready,
	input  wire logic [31:0]   wdata,
	input  wire logic [3:0]    wstrb,
	input  wire logic          wvalid,
	output logic               wready,
	output logic [1:0]         bresp,
	output logic               bvalid,
	input  wire logic          bready,
	// axi4-lite read
	input  wire logic [AW-1:0] araddr,
	input  wire logic          arvalid,
	output logic               arready,
	output logic [31:0]        rdata,
	output logic [1:0]         rresp,
	output logic               rvalid,
	input  wire logic          rready,
	// serial pins
	input  wire logic          sck_i,
	output logic               sck_o,
	output logic               sck_oe_n,
	input  wire logic          mosi_i,
	output logic               mosi_o,
	output logic               mosi_oe_n,
	input  wire logic          miso_i,
	output logic               miso_o,
	output logic               miso_oe_n,
	input  wire logic          ss_n_i,
	output logic               ss_n_o,
	output logic               ss_n_oe_n,
	// interrupts
	output logic               port_irq,
	output logic               irq
);
	logic [7:0]               ctrl_r;
	logic [7:0]               pins_r;
	logic                     dbl_r;
	logic                     flag_r;
	logic                     wcol_r;
	logic                     clr_arm_r;
	logic [7:0]               tx_r;
	logic [7:0]               rx_r;
	logic [7:0]               rx_nxt;
	logic [7:0]               rbuf_r;
	logic [3:0]               edge_cnt_r;
	logic [2:0]               bit_cnt_r;
	logic [6:0]               half_cnt_r;
	logic [6:0]               half_val;
	logic                     sck_int_r;
	logic                     first_r;
	logic [1:0]               samp_r;
	spsc_pkg::spsc_state_t    st_r;
	logic [spsc_pkg::EV_W-1:0] irq_st_r;
	logic [spsc_pkg::EV_W-1:0] irq_msk_r;
	logic [spsc_pkg::EV_W-1:0] ev;
	logic [3:0]               s1_r;
	logic [3:0]               s2_r;
	logic                     sck_d_r;
	logic                     sck_s, mosi_s, miso_s, ss_s;
	logic                     en, master_select_bit, slave_act, m_edge, s_edge, any_edge;
	logic                     lead, sample_e, setup_e, in_bit, done, modf, m_samp, edges_done;
	logic                     wr_go, rd_go, data_wr, data_acc, stat_rd, irq_rd;
	logic [7:0]               wa, ra, rd_mux;
	logic [31:0]              rdata_r;
	logic [1:0]               rresp_r;
	logic                     rvalid_r, bvalid_r;
	logic [1:0]               bresp_r;

	// pin inputs cross from outside: two flops each
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			s1_r <= 4'hf;
			s2_r <= 4'hf;
		end else if (ce) begin
			s1_r <= {ss_n_i, miso_i, mosi_i, sck_i};
			s2_r <= s1_r; // [R14]
		end
	end
	assign sck_s  = s2_r[0];
	assign mosi_s = s2_r[1];
	assign miso_s = s2_r[2];
	assign ss_s   = s2_r[3];

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			sck_d_r <= 1'b1; // same as synchroniser reset: no false edge
		end else if (ce) begin
			sck_d_r <= sck_s;
		end
	end

	assign en   = ctrl_r[spsc_pkg::CTL_EN];
	assign master_select_bit = ctrl_r[spsc_pkg::CTL_MASTER_SELECT_BIT];
	// deselected slave sees no edges at all
	assign slave_act = en && !master_select_bit && !ss_s; // [R02] [R03]
	// another master pulls our select low
	assign modf = en && master_select_bit && !pins_r[spsc_pkg::PIN_SS_DIR] && !ss_s; // [R07]

	// master sck divider, rate ignored by the slave path
	always_comb begin
		half_val = 7'(spsc_pkg::SCK_DIV[{dbl_r, ctrl_r[1:0]}] / 2); // [R13]
	end
	// after sixteen edges sck rests while late samples drain
	assign edges_done = master_select_bit && (st_r == spsc_pkg::SH_SHIFT) && (edge_cnt_r == 4'h0)
	                    && !first_r;
	assign m_edge   = master_select_bit && (st_r == spsc_pkg::SH_SHIFT) && (half_cnt_r == 7'h0)
	                  && !edges_done;
	assign s_edge   = slave_act && (sck_s != sck_d_r);
	assign any_edge = m_edge || s_edge;
	// leading edge leaves the idle level
	assign lead     = master_select_bit ? !edge_cnt_r[0] : (sck_s != ctrl_r[spsc_pkg::CTL_CPOL]); // [R12]
	assign m_samp   = m_edge && (lead != ctrl_r[spsc_pkg::CTL_CPHA]);
	// master takes miso two clocks late, the synchroniser's lag
	assign sample_e = master_select_bit ? samp_r[1]
	                       : (s_edge && (lead != ctrl_r[spsc_pkg::CTL_CPHA])); // [R12]
	assign setup_e  = any_edge && (lead == ctrl_r[spsc_pkg::CTL_CPHA]);
	assign in_bit   = master_select_bit ? miso_s : mosi_s;
	assign done     = master_select_bit ? (edges_done && samp_r == 2'b00)
	                       : (sample_e && bit_cnt_r == spsc_pkg::LAST_BIT);

	always_comb begin
		if (ctrl_r[spsc_pkg::CTL_LSB]) begin
			rx_nxt = {in_bit, rx_r[7:1]}; // [R11]
		end else begin
			rx_nxt = {rx_r[6:0], in_bit};
		end
	end

	// bus decode
	assign wa      = awaddr[7:0];
	assign ra      = araddr[7:0];
	assign wr_go   = ce && awvalid && wvalid && !bvalid_r;
	assign rd_go   = ce && arvalid && !rvalid_r;
	assign data_wr = wr_go && wstrb[0] && wa == spsc_pkg::OFS_DATA;
	assign stat_rd = rd_go && ra == spsc_pkg::OFS_STAT;
	assign irq_rd  = rd_go && ra == spsc_pkg::OFS_IRQ_ST;
	assign data_acc = data_wr || (rd_go && ra == spsc_pkg::OFS_DATA);

	// control register, hardware drops master on a conflict
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			ctrl_r <= spsc_pkg::CTRL_RST;
		end else if (ce) begin
			if (wr_go && wstrb[0] && wa == spsc_pkg::OFS_CTRL) begin
				ctrl_r <= wdata[7:0]; // [R10]
			end
			if (modf) begin
				ctrl_r[spsc_pkg::CTL_MASTER_SELECT_BIT] <= 1'b0; // [R07] [R09]
			end
		end
	end

	// pin control, double rate and interrupt mask
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			pins_r    <= spsc_pkg::PINS_RST;
			dbl_r     <= 1'b0;
			irq_msk_r <= spsc_pkg::MSK_RST;
		end else if (ce && wr_go && wstrb[0]) begin
			if (wa == spsc_pkg::OFS_PINS) begin
				pins_r <= wdata[7:0];
			end
			if (wa == spsc_pkg::OFS_STAT) begin
				dbl_r <= wdata[spsc_pkg::ST_DBL];
			end
			if (wa == spsc_pkg::OFS_IRQ_MSK) begin
				irq_msk_r <= wdata[spsc_pkg::EV_W-1:0];
			end
		end
	end

	// shift engine
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			st_r       <= spsc_pkg::SH_IDLE;
			edge_cnt_r <= 4'h0;
			bit_cnt_r  <= 3'h0;
			half_cnt_r <= 7'h0;
			sck_int_r  <= 1'b0;
			samp_r     <= 2'b00;
			first_r    <= 1'b1;
			tx_r       <= spsc_pkg::DATA_RST;
			rx_r       <= spsc_pkg::DATA_RST;
		end else if (ce) begin
			if (!en || modf || (!master_select_bit && ss_s)) begin
				// deselect throws away a part byte at once
				st_r       <= spsc_pkg::SH_IDLE; // [R04]
				edge_cnt_r <= 4'h0;
				bit_cnt_r  <= 3'h0; // [R04]
				rx_r       <= spsc_pkg::DATA_RST;
				first_r    <= 1'b1;
				sck_int_r  <= ctrl_r[spsc_pkg::CTL_CPOL];
				samp_r     <= 2'b00;
				if (data_wr && st_r == spsc_pkg::SH_IDLE) begin
					tx_r <= wdata[7:0];
				end
			end else begin
				if (data_wr && st_r == spsc_pkg::SH_IDLE) begin
					tx_r       <= wdata[7:0];
					half_cnt_r <= half_val - 7'h1;
					if (master_select_bit) begin
						st_r <= spsc_pkg::SH_SHIFT;
						first_r    <= 1'b1;
						edge_cnt_r <= 4'h0;
						bit_cnt_r  <= 3'h0;
					end
				end
				if (st_r == spsc_pkg::SH_IDLE && master_select_bit) begin
					sck_int_r <= ctrl_r[spsc_pkg::CTL_CPOL]; // [R12]
				end
				if (master_select_bit && st_r == spsc_pkg::SH_SHIFT) begin
					half_cnt_r <= (half_cnt_r == 7'h0) ? half_val - 7'h1 : half_cnt_r - 7'h1;
				end
				if (m_edge) begin
					sck_int_r  <= !sck_int_r;
					edge_cnt_r <= edge_cnt_r + 4'h1;
				end
				if (s_edge && !master_select_bit) begin
					st_r <= spsc_pkg::SH_SHIFT;
				end
				if (any_edge) begin
					first_r <= 1'b0;
				end
				samp_r <= {samp_r[0], m_samp};
				if (sample_e) begin
					rx_r      <= rx_nxt;
					bit_cnt_r <= bit_cnt_r + 3'h1;
				end
				// phase one: first leading edge only presents bit 0
				if (setup_e && !(ctrl_r[spsc_pkg::CTL_CPHA] && first_r)) begin
					if (ctrl_r[spsc_pkg::CTL_LSB]) begin
						tx_r <= {1'b0, tx_r[7:1]}; // [R11]
					end else begin
						tx_r <= {tx_r[6:0], 1'b0};
					end
				end
				if (done) begin
					st_r       <= spsc_pkg::SH_IDLE;
					edge_cnt_r <= 4'h0;
					bit_cnt_r  <= 3'h0;
					first_r    <= 1'b1;
				end
			end
		end
	end

	// receive buffer keeps the last whole byte
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			rbuf_r <= spsc_pkg::DATA_RST;
		end else if (ce && done) begin
			rbuf_r <= master_select_bit ? rx_r : rx_nxt; // master byte already whole once drained
		end
	end

	// transfer flag and collision: set wins over the clear
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			flag_r    <= 1'b0;
			wcol_r    <= 1'b0;
			clr_arm_r <= 1'b0;
		end else if (ce) begin
			if (stat_rd && (flag_r || wcol_r)) begin
				clr_arm_r <= 1'b1;
			end else if (data_acc) begin
				clr_arm_r <= 1'b0;
			end
			if (done || modf) begin
				flag_r <= 1'b1; // [R08]
			end else if (clr_arm_r && data_acc) begin
				flag_r <= 1'b0;
			end
			if (data_wr && st_r == spsc_pkg::SH_SHIFT) begin
				wcol_r <= 1'b1;
			end else if (clr_arm_r && data_acc) begin
				wcol_r <= 1'b0;
			end
		end
	end

	// sticky event bits, cleared by reading them
	assign ev[spsc_pkg::EV_DONE] = done;
	assign ev[spsc_pkg::EV_MODF] = modf;
	assign ev[spsc_pkg::EV_WCOL] = data_wr && st_r == spsc_pkg::SH_SHIFT;
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			irq_st_r <= '0;
		end else if (ce) begin
			irq_st_r <= (irq_rd ? '0 : irq_st_r) | ev;
		end
	end
	assign irq      = |(irq_st_r & irq_msk_r);
	assign port_irq = flag_r && ctrl_r[spsc_pkg::CTL_IE] && pins_r[spsc_pkg::PIN_GIE]; // [R08]

	// pin drivers, enable low while driving
	assign sck_o     = sck_int_r;
	assign mosi_o    = ctrl_r[spsc_pkg::CTL_LSB] ? tx_r[0] : tx_r[7];
	assign miso_o    = mosi_o;
	assign ss_n_o    = pins_r[spsc_pkg::PIN_SS_OUT]; // [R05]
	assign sck_oe_n  = !(en && master_select_bit && pins_r[spsc_pkg::PIN_SCK_DIR]); // [R07]
	assign mosi_oe_n = !(en && master_select_bit && pins_r[spsc_pkg::PIN_MOSI_DIR]); // [R07]
	assign miso_oe_n = !(slave_act && pins_r[spsc_pkg::PIN_MISO_DIR]); // [R02] [R03]
	// slave mode never drives select; master may use it freely
	assign ss_n_oe_n = !(pins_r[spsc_pkg::PIN_SS_DIR] && !(en && !master_select_bit)); // [R01] [R05]

	// read mux
	always_comb begin
		case (ra)
			spsc_pkg::OFS_CTRL:    rd_mux = ctrl_r;
			spsc_pkg::OFS_STAT:    rd_mux = {flag_r, wcol_r, 5'h00, dbl_r};
			spsc_pkg::OFS_DATA:    rd_mux = rbuf_r;
			spsc_pkg::OFS_PINS:    rd_mux = pins_r;
			spsc_pkg::OFS_IRQ_ST:  rd_mux = {5'h00, irq_st_r};
			spsc_pkg::OFS_IRQ_MSK: rd_mux = {5'h00, irq_msk_r};
			default:               rd_mux = 8'h00;
		endcase
	end

	// bus answers
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			bvalid_r <= 1'b0;
			bresp_r  <= spsc_pkg::RESP_OKAY;
		end else if (ce) begin
			if (wr_go) begin
				bvalid_r <= 1'b1;
				bresp_r  <= (wa[1:0] == 2'h0 && wa <= spsc_pkg::OFS_IRQ_MSK) ?
				            spsc_pkg::RESP_OKAY : spsc_pkg::RESP_SLVERR;
			end else if (bready) begin
				bvalid_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			rvalid_r <= 1'b0;
			rdata_r  <= 32'h0;
			rresp_r  <= spsc_pkg::RESP_OKAY;
		end else if (ce) begin
			if (rd_go) begin
				rvalid_r <= 1'b1;
				rdata_r  <= {24'h0, rd_mux};
				rresp_r  <= (ra[1:0] == 2'h0 && ra <= spsc_pkg::OFS_IRQ_MSK) ?
				            spsc_pkg::RESP_OKAY : spsc_pkg::RESP_SLVERR;
			end else if (rready) begin
				rvalid_r <= 1'b0;
			end
		end
	end

	assign awready = wr_go;
	assign wready  = wr_go;
	assign bvalid  = bvalid_r;
	assign bresp   = bresp_r;
	assign arready = rd_go;
	assign rvalid  = rvalid_r;
	assign rdata   = rdata_r;
	assign rresp   = rresp_r;

	// checks
	logic [6:0] gap_r;
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			gap_r <= 7'h0;
		end else if (ce) begin
			gap_r <= (m_edge || st_r == spsc_pkg::SH_IDLE) ? 7'h1 : gap_r + 7'h1;
		end
	end

	default clocking @(posedge clock); endclocking
	default disable iff (rst || !ce);

	sequence fault_s;
		modf;
	endsequence
	sequence deselect_s;
		en && !master_select_bit && $rose(ss_s);
	endsequence

	slave_ss_input_a: assert property (en && !master_select_bit |-> ss_n_oe_n) // [R01]
		else $error("select driven in slave mode");
	slave_miso_a: assert property (slave_act && pins_r[1] |-> !miso_oe_n) // [R02]
		else $error("selected slave not driving miso");
	idle_quiet_a: assert property (en && !master_select_bit && ss_s |-> miso_oe_n && sck_oe_n && mosi_oe_n) // [R03]
		else $error("deselected slave drives a pin");
	ss_reset_a: assert property (deselect_s |=> bit_cnt_r == 3'h0 && st_r == spsc_pkg::SH_IDLE) // [R04]
		else $error("deselect did not reset shift logic");
	ss_gpo_a: assert property (en && master_select_bit && pins_r[3] |-> !ss_n_oe_n && ss_n_o == pins_r[4]) // [R05]
		else $error("master select output wrong");
	fault_mode_a: assert property (fault_s |=> !master_select_bit && flag_r && sck_oe_n && mosi_oe_n) // [R07]
		else $error("conflict did not drop to slave");
	fault_irq_a: assert property (fault_s ##1 (ctrl_r[7] && pins_r[7]) |-> port_irq) // [R08]
		else $error("conflict flag raised no interrupt");
	ctrl_rw_a: assert property (wr_go && wstrb[0] && wa == 8'h00 && !modf |=> ctrl_r == $past(wdata[7:0])) // [R10]
		else $error("control write lost");
	first_bit_a: assert property (data_wr && st_r == spsc_pkg::SH_IDLE && en
		|=> mosi_o == (ctrl_r[5] ? $past(wdata[0]) : $past(wdata[7]))) // [R11]
		else $error("first bit order wrong");
	sck_idle_a: assert property (master_select_bit && st_r == spsc_pkg::SH_IDLE ##1 master_select_bit && st_r == spsc_pkg::SH_IDLE
		|-> sck_o == $past(ctrl_r[3])) // [R12]
		else $error("sck not at idle level");
	rate_a: assert property (m_edge && edge_cnt_r != 4'h0 |-> gap_r == half_val) // [R13]
		else $error("sck half period wrong");
	ss_sync_a: assert property ($fell(ss_n_i) ##1 !ss_n_i |=> !ss_s) // [R14]
		else $error("select not seen after two flops");
endmodule

// file: spsc_pkg.sv
// constants of the serial port select and control block
package spsc_pkg;
	// register byte offsets
	localparam logic [7:0] OFS_CTRL    = 8'h00;
	localparam logic [7:0] OFS_STAT    = 8'h04;
	localparam logic [7:0] OFS_DATA    = 8'h08;
	localparam logic [7:0] OFS_PINS    = 8'h0c;
	localparam logic [7:0] OFS_IRQ_ST  = 8'h10;
	localparam logic [7:0] OFS_IRQ_MSK = 8'h14;
	// control field positions
	localparam int CTL_IE   = 7;
	localparam int CTL_EN   = 6;
	localparam int CTL_LSB  = 5;
	localparam int CTL_MASTER_SELECT_BIT = 4;
	localparam int CTL_CPOL = 3;
	localparam int CTL_CPHA = 2;
	localparam int CTL_RHI  = 1;
	localparam int CTL_RLO  = 0;
	// status field positions
	localparam int ST_FLAG = 7;
	localparam int ST_WCOL = 6;
	localparam int ST_DBL  = 0;
	// pin control field positions
	localparam int PIN_MOSI_DIR = 0;
	localparam int PIN_MISO_DIR = 1;
	localparam int PIN_SCK_DIR  = 2;
	localparam int PIN_SS_DIR   = 3;
	localparam int PIN_SS_OUT   = 4;
	localparam int PIN_GIE      = 7;
	// interrupt event bits
	localparam int EV_DONE = 0;
	localparam int EV_MODF = 1;
	localparam int EV_WCOL = 2;
	localparam int EV_W    = 3;
	// reset values
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [7:0] PINS_RST = 8'h10;
	localparam logic [7:0] DATA_RST = 8'h00;
	localparam logic [EV_W-1:0] MSK_RST = 3'h0;
	// sck divisions indexed by {double, rate_hi, rate_lo}
	localparam int SCK_DIV [0:7] = '{4, 16, 64, 128, 2, 8, 32, 64};
	localparam int BYTE_BITS = 8;
	localparam logic [3:0] LAST_EDGE = 4'hf;
	localparam logic [2:0] LAST_BIT  = 3'h7;
	// bus answers
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// shift engine states
	typedef enum logic [1:0] {
		SH_IDLE  = 2'b01,
		SH_SHIFT = 2'b10
	} spsc_state_t;
endpackage

// file: spsc_far.sv
// far-end model of the serial link: slave to a master dut, master to a slave dut
`timescale 1ns/100ps
module spsc_far (
	// wire levels
	input  wire logic sck,
	input  wire logic mosi,
	input  wire logic miso,
	input  wire logic ss_n,
	// framing of the slave role
	input  wire logic cpol,
	input  wire logic cpha,
	input  wire logic lsb,
	// levels this model drives
	output logic      p_sck,
	output logic      p_mosi,
	output logic      p_miso,
	output logic      p_ss_n
);
	logic [7:0] tx_sh;
	logic [7:0] rx_sh;
	// select held high except during xfer frames or a staged conflict
	initial p_ss_n = 1'b1;
	initial p_sck = 1'b0;
	initial p_mosi = 1'b0;
	initial p_miso = 1'b0;
	task automatic put_bit();
		p_miso = lsb ? tx_sh[0] : tx_sh[7];
		tx_sh = lsb ? tx_sh >> 1 : tx_sh << 1;
	endtask
	always @(negedge ss_n) if (p_ss_n && !cpha) put_bit();
	// released line shows the inverse, never a stale bit
	always @(posedge ss_n) p_miso = ~p_miso;
	always @(sck) begin
		if (!ss_n && p_ss_n) begin
			if ((sck !== cpol) ^ cpha)
				rx_sh = lsb ? {mosi, rx_sh[7:1]} : {rx_sh[6:0], mosi};
			else
				put_bit();
		end
	end
	// master role, mode 0, msb first; sck stands still outside frames
	task automatic xfer(input logic [7:0] d, input int n, output logic [7:0] got);
		got = 8'h00;
		// keep pin moves off the dut's sampling edge
		#1;
		p_ss_n = 1'b0;
		for (int i = 7; i > 7 - n; i--) begin
			p_mosi = d[i];
			#62.5 p_sck = 1'b1;
			got[i] = miso;
			#62.5 p_sck = 1'b0;
		end
		#62.5 p_ss_n = 1'b1;
		p_mosi = ~p_mosi;
	endtask
	task automatic hold_ss(input logic v);
		p_ss_n <= v;
	endtask
endmodule

// file: tb_top.sv
// self-checking bench: bus tasks, far-end model, queued read checks
`timescale 1ns/100ps
module tb_top;
	typedef struct {
		string       n;
		logic [31:0] d;
		logic [31:0] m;
		logic [1:0]  r;
	} spsc_exp_t;
	spsc_exp_t   exq[$];
	spsc_exp_t   ex;
	logic        clock = 1'b0;
	logic        rst = 1'b1;
	logic        ce = 1'b1;
	logic [7:0]  awaddr = 8'h00;
	logic        awvalid = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [3:0]  wstrb = 4'h1;
	logic        wvalid = 1'b0;
	logic        bready = 1'b0;
	logic [7:0]  araddr = 8'h00;
	logic        arvalid = 1'b0;
	logic        rready = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata;
	logic        sck_o, sck_oe_n, mosi_o, mosi_oe_n, miso_o, miso_oe_n;
	logic        ss_n_o, ss_n_oe_n, port_irq, irq;
	logic        p_sck, p_mosi, p_miso, p_ss_n;
	logic        m_cpol = 1'b0;
	logic        m_cpha = 1'b0;
	logic        m_lsb = 1'b0;
	wire         sck = !sck_oe_n ? sck_o : p_sck;
	wire         mosi = !mosi_oe_n ? mosi_o : p_mosi;
	wire         miso = !miso_oe_n ? miso_o : p_miso;
	wire         ss_n = !ss_n_oe_n ? ss_n_o : p_ss_n;
	int          fail_count = 0;
	int          n_tests = 0;
	int          act_cnt = 0;
	spsc_top u_dut (
		.clock(clock), .rst(rst), .ce(ce),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.sck_i(sck), .sck_o(sck_o), .sck_oe_n(sck_oe_n),
		.mosi_i(mosi), .mosi_o(mosi_o), .mosi_oe_n(mosi_oe_n),
		.miso_i(miso), .miso_o(miso_o), .miso_oe_n(miso_oe_n),
		.ss_n_i(ss_n), .ss_n_o(ss_n_o), .ss_n_oe_n(ss_n_oe_n),
		.port_irq(port_irq), .irq(irq)
	);
	spsc_far u_far (
		.sck(sck), .mosi(mosi), .miso(miso), .ss_n(ss_n),
		.cpol(m_cpol), .cpha(m_cpha), .lsb(m_lsb),
		.p_sck(p_sck), .p_mosi(p_mosi), .p_miso(p_miso), .p_ss_n(p_ss_n)
	);
	initial begin
		forever #5 clock = ~clock;
	end
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
		awaddr <= a;
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		@(posedge clock);
		while (!awready) @(posedge clock);
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		while (!bvalid) @(posedge clock);
		bready <= 1'b0;
		chk("bresp", {30'h0, er}, {30'h0, bresp});
		@(posedge clock);
	endtask
	task automatic rd(input string n, input logic [7:0] a, input logic [7:0] e,
			input logic [7:0] m, input logic [1:0] er);
		exq.push_back('{n, {24'h0, e & m}, {24'h0, m}, er});
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		@(posedge clock);
		while (!arready) @(posedge clock);
		arvalid <= 1'b0;
		while (!rvalid) @(posedge clock);
		rready <= 1'b0;
		@(posedge clock);
	endtask
	task automatic wait_irq();
		int i;
		i = 0;
		while (irq !== 1'b1 && i < 20000) begin
			@(posedge clock);
			i++;
		end
		chk("irq", 32'h1, {31'h0, irq});
	endtask
	// read results are matched in issue order
	always @(posedge clock) begin
		if (rvalid === 1'b1 && rready === 1'b1) begin
			ex = exq.pop_front();
			chk(ex.n, ex.d, rdata & ex.m);
			chk("rresp", {30'h0, ex.r}, {30'h0, rresp});
		end
	end
	// active-level clocks of the driven sck, for the rate check
	always @(posedge clock) begin
		if (!sck_oe_n && sck_o !== m_cpol)
			act_cnt <= act_cnt + 1;
	end
	initial begin
		#600000;
		fail_count++;
		close_out();
	end
	initial begin
		logic [7:0] v;
		logic [7:0] w;
		logic [7:0] got;
		logic [7:0] cv;
		int         h0;
		void'($urandom(32'h2d17));
		repeat (12) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		rd("ctrl rst", spsc_pkg::OFS_CTRL, spsc_pkg::CTRL_RST, 8'hff, 2'h0);
		rd("pins rst", spsc_pkg::OFS_PINS, spsc_pkg::PINS_RST, 8'hff, 2'h0);
		v = 8'($urandom()) & 8'hbf;
		for (int i = 0; i < 2; i++) begin
			wr(spsc_pkg::OFS_CTRL, v, 2'h0);
			rd("ctrl rw", spsc_pkg::OFS_CTRL, v, 8'hff, 2'h0);
			v = ~v & 8'hbf;
		end
		wr(8'h20, 8'h55, spsc_pkg::RESP_SLVERR);
		rd("unmapped", 8'h20, 8'h00, 8'hff, spsc_pkg::RESP_SLVERR);
		wr(spsc_pkg::OFS_IRQ_MSK, 8'h03, 2'h0);
		// slave role: far end clocks a byte, then a torn frame, then a byte
		wr(spsc_pkg::OFS_PINS, 8'h12, 2'h0);
		wr(spsc_pkg::OFS_CTRL, 8'h40, 2'h0);
		wr(spsc_pkg::OFS_DATA, 8'ha5, 2'h0);
		chk("idle oe", 32'hf, {28'h0, ss_n_oe_n, miso_oe_n, mosi_oe_n, sck_oe_n});
		fork
			u_far.xfer(8'h3c, 8, got);
			#50 chk("sel oe", 32'hb, {28'h0, ss_n_oe_n, miso_oe_n, mosi_oe_n, sck_oe_n});
		join
		@(posedge clock);
		chk("slave tx", 32'ha5, {24'h0, got});
		wait_irq();
		rd("irq st", spsc_pkg::OFS_IRQ_ST, 8'h01, 8'h07, 2'h0);
		rd("status", spsc_pkg::OFS_STAT, 8'h80, 8'hc0, 2'h0);
		rd("slave rx", spsc_pkg::OFS_DATA, 8'h3c, 8'hff, 2'h0);
		u_far.xfer(8'hff, 3, got);
		repeat (8) @(posedge clock);
		chk("torn frame", 32'h0, {31'h0, irq});
		u_far.xfer(8'h96, 8, got);
		@(posedge clock);
		wait_irq();
		rd("irq st", spsc_pkg::OFS_IRQ_ST, 8'h01, 8'h07, 2'h0);
		rd("rx after torn", spsc_pkg::OFS_DATA, 8'h96, 8'hff, 2'h0);
		// master role over every rate, order and clock mode
		for (int r = 0; r < 8; r++) begin
			v = 8'($urandom());
			w = 8'($urandom());
			cv = {2'b01, r[0], 1'b1, r[1], r[2], r[1:0]};
			m_lsb <= r[0];
			m_cpol <= r[1];
			m_cpha <= r[2];
			wr(spsc_pkg::OFS_STAT, {7'h0, r[2]}, 2'h0);
			wr(spsc_pkg::OFS_PINS, 8'h1d, 2'h0);
			wr(spsc_pkg::OFS_CTRL, cv, 2'h0);
			u_far.tx_sh = w;
			wr(spsc_pkg::OFS_PINS, 8'h0d, 2'h0);
			chk("ss out", 32'h0, {30'h0, ss_n_oe_n, ss_n_o});
			chk("sck idle", {31'h0, r[1]}, {30'h0, sck_oe_n, sck_o});
			h0 = act_cnt;
			wr(spsc_pkg::OFS_DATA, v, 2'h0);
			wait_irq();
			chk("sck active", 32'(4 * spsc_pkg::SCK_DIV[r]), 32'(act_cnt - h0));
			chk("far rx", {24'h0, v}, {24'h0, u_far.rx_sh});
			rd("irq st", spsc_pkg::OFS_IRQ_ST, 8'h01, 8'h07, 2'h0);
			rd("master rx", spsc_pkg::OFS_DATA, w, 8'hff, 2'h0);
			wr(spsc_pkg::OFS_PINS, 8'h1d, 2'h0);
			rd("ctrl kept", spsc_pkg::OFS_CTRL, cv, 8'hff, 2'h0);
		end
		// another master pulls select low
		rd("status", spsc_pkg::OFS_STAT, 8'h80, 8'h80, 2'h0);
		rd("data", spsc_pkg::OFS_DATA, 8'h00, 8'h00, 2'h0);
		wr(spsc_pkg::OFS_PINS, 8'h85, 2'h0);
		wr(spsc_pkg::OFS_CTRL, 8'hd0, 2'h0);
		chk("port irq idle", 32'h0, {31'h0, port_irq});
		u_far.hold_ss(1'b0);
		repeat (4) @(posedge clock);
		chk("forced in", 32'h3, {30'h0, mosi_oe_n, sck_oe_n});
		chk("port irq", 32'h1, {31'h0, port_irq});
		wr(spsc_pkg::OFS_IRQ_MSK, 8'h01, 2'h0);
		chk("irq masked", 32'h0, {31'h0, irq});
		wr(spsc_pkg::OFS_IRQ_MSK, 8'h03, 2'h0);
		chk("irq unmasked", 32'h1, {31'h0, irq});
		rd("ctrl dropped", spsc_pkg::OFS_CTRL, 8'hc0, 8'hff, 2'h0);
		rd("irq st", spsc_pkg::OFS_IRQ_ST, 8'h02, 8'h07, 2'h0);
		u_far.hold_ss(1'b1);
		wr(spsc_pkg::OFS_PINS, 8'h05, 2'h0);
		chk("irq cleared", 32'h0, {30'h0, irq, port_irq});
		wr(spsc_pkg::OFS_CTRL, 8'hd0, 2'h0);
		rd("master again", spsc_pkg::OFS_CTRL, 8'hd0, 8'hff, 2'h0);
		close_out();
	end
endmodule
